// File: hw/rx_buffer2.sv
// two-entry receive buffer with registered head entry
`timescale 1ns/1ps
`default_nettype none
module rx_buffer2
	import serial_engine_pkg::*;
(
	input  wire logic      i_ref_clk,
	input  wire logic      i_rst,
	input  wire logic      i_push,
	input  wire rx_entry_t i_data,
	input  wire logic      i_pop,
	output rx_entry_t      o_head,
	output logic [1:0]     o_count
);
	rx_entry_t  head_r;
	rx_entry_t  tail_r;
	logic [1:0] cnt_r;
	logic       push_ok;
	logic       pop_ok;

	// a push into a full buffer is refused; the parent flags the overflow
	assign push_ok = i_push && (cnt_r != 2'd2);
	assign pop_ok  = i_pop && (cnt_r != 2'd0);

	// head is always a flop so the bus sees stable read data
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			head_r <= '0;
			tail_r <= '0;
			cnt_r  <= 2'd0;
		end else begin
			case ({push_ok, pop_ok})
				2'b10: begin
					if (cnt_r == 2'd0) begin
						head_r <= i_data;
					end else begin
						tail_r <= i_data;
					end
					cnt_r <= cnt_r + 2'd1;
				end
				2'b01: begin
					head_r <= tail_r;
					cnt_r  <= cnt_r - 2'd1;
				end
				2'b11: begin
					if (cnt_r == 2'd1) begin
						head_r <= i_data;
					end else begin
						head_r <= tail_r;
						tail_r <= i_data;
					end
				end
				default: begin
					cnt_r <= cnt_r;
				end
			endcase
		end
	end

	assign o_head  = head_r;
	assign o_count = cnt_r;
endmodule
`default_nettype wire

// File: hw/serial_engine.sv
// serial engine: ahb-lite registers, baud generator, tx/rx, match, irq
`timescale 1ns/1ps
`default_nettype none
module serial_engine
	import serial_engine_pkg::*;
(
	input  wire logic     i_ref_clk,
	input  wire logic     i_rst,
	input  wire ahb_req_t i_ahb,
	output ahb_rsp_t      o_ahb,
	input  wire logic     i_ext_clk,
	input  wire logic     i_rxd,
	output logic          o_txd,
	output logic          o_irq,
	output logic          o_wake
);
	// bus side registers
	logic [31:0]     ctrla_r;
	logic [15:0]     baud_r;
	logic [31:0]     addr_r;
	logic [NFLAG-1:0] flag_r;
	logic [NFLAG-1:0] inten_r;
	logic [31:0]     hrdata_r;
	logic            wr_pend_r;
	logic [11:0]     wr_addr_r;
	// core side copies
	logic [1:0]      sync_sh_r;
	logic [31:0]     ctrla_core_r;
	logic [15:0]     baud_core_r;
	// pin synchronisers
	logic            rxd_m_r;
	logic            rxd_s_r;
	logic            ext_m_r;
	logic            ext_s_r;
	logic            ext_d_r;
	// baud generator
	logic [15:0]     acc_r;
	logic [16:0]     acc_sum;
	logic            ref_tick;
	logic            baud_tick;
	// transmitter
	tx_state_t       tx_state_r;
	logic [7:0]      txbuf_r;
	logic            txbuf_full_r;
	logic [9:0]      tx_sh_r;
	logic [3:0]      tx_samp_r;
	logic [3:0]      tx_bit_r;
	logic [15:0]     frm_cnt_r;
	logic [15:0]     frm_len_r;
	logic [7:0]      frm_samp_r;
	logic            tx_frame_end;
	// receiver
	rx_state_t       rx_state_r;
	logic [3:0]      rx_samp_r;
	logic [3:0]      rx_bit_r;
	logic [7:0]      rx_sh_r;
	logic            rx_done;
	rx_entry_t       rx_entry;
	rx_entry_t       rx_head;
	logic [1:0]      rx_count;
	// decode and matching
	logic            req;
	logic            rd_data_pop;
	logic            run;
	operating_mode_t mode;
	addr_mode_t      amode;
	logic [7:0]      match_val;
	logic [7:0]      match_mask_field;
	logic [7:0]      cmp_in;
	logic            addr_hit;
	logic [NFLAG-1:0] flag_set;
	logic [NFLAG-1:0] flag_clr;
	logic            wr_ctl;

	// ahb-lite: zero wait state, always okay
	assign req = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
	assign rd_data_pop = req && !i_ahb.hwrite
		&& (i_ahb.haddr[11:0] == OFS_DATA);
	assign o_ahb.hrdata    = hrdata_r;
	assign o_ahb.hreadyout = 1'b1;
	assign o_ahb.hresp     = 1'b0;

	// address phase capture; read data registered for the data phase
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hrdata_r  <= 32'h0000_0000;
		end else begin
			wr_pend_r <= req && i_ahb.hwrite;
			wr_addr_r <= i_ahb.haddr[11:0];
			if (req && !i_ahb.hwrite) begin
				if (i_ahb.haddr[11:0] == OFS_CTRLA) begin
					hrdata_r <= ctrla_r;
				end else if (i_ahb.haddr[11:0] == OFS_BAUD) begin
					hrdata_r <= {16'h0000, baud_r};
				end else if (i_ahb.haddr[11:0] == OFS_ADDR) begin
					hrdata_r <= addr_r;
				end else if (i_ahb.haddr[11:0] == OFS_IRQ_FLAG) begin
					hrdata_r <= {27'h000_0000, flag_r};
				end else if (i_ahb.haddr[11:0] == OFS_IRQ_ENSET
					|| i_ahb.haddr[11:0] == OFS_IRQ_ENCLR) begin
					hrdata_r <= {27'h000_0000, inten_r};
				end else if (i_ahb.haddr[11:0] == OFS_DATA) begin
					hrdata_r <= {23'h00_0000, rx_head};
				end else if (i_ahb.haddr[11:0] == OFS_STATUS) begin
					hrdata_r <= {frm_len_r, 11'h000, txbuf_full_r,
						tx_state_r == TX_SHIFT, rx_count,
						|sync_sh_r};
				end else begin
					hrdata_r <= 32'h0000_0000;
				end
			end
		end
	end

	// control, baud and address registers, written in the data phase
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrla_r <= CTRLA_RST;
			baud_r  <= BAUD_RST;
			addr_r  <= ADDR_RST;
		end else if (wr_pend_r) begin
			if (wr_addr_r == OFS_CTRLA) begin
				ctrla_r <= i_ahb.hwdata;
			end else if (wr_addr_r == OFS_BAUD) begin
				baud_r <= i_ahb.hwdata[15:0];
			end else if (wr_addr_r == OFS_ADDR) begin
				addr_r <= i_ahb.hwdata;
			end
		end
	end

	// core copies follow two cycles behind so a half-written value never
	// reaches the shifters mid-update
	assign wr_ctl = wr_pend_r
		&& (wr_addr_r == OFS_CTRLA || wr_addr_r == OFS_BAUD);
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_sh_r    <= 2'b00;
			ctrla_core_r <= CTRLA_RST;
			baud_core_r  <= BAUD_RST;
		end else begin
			sync_sh_r <= {sync_sh_r[0], wr_ctl};
			if (sync_sh_r[1]) begin
				ctrla_core_r <= ctrla_r;
				baud_core_r  <= baud_r;
			end
		end
	end

	// mode decode; reserved codes leave the engine stopped
	assign mode  = operating_mode_t'(ctrla_core_r[OPERATING_MODE_FIELD_LSB +: 3]);
	assign amode = addr_mode_t'(ctrla_r[CTRLA_AMODE_LSB +: 2]);
	assign run   = ctrla_core_r[CTRLA_EN_BIT]
		&& (mode == MODE_USART_EXT || mode == MODE_USART_INT);

	// pin synchronisers: first flop feeds only the second
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rxd_m_r <= 1'b1;
			rxd_s_r <= 1'b1;
			ext_m_r <= 1'b0;
			ext_s_r <= 1'b0;
			ext_d_r <= 1'b0;
		end else begin
			rxd_m_r <= i_rxd;
			rxd_s_r <= rxd_m_r;
			ext_m_r <= i_ext_clk;
			ext_s_r <= ext_m_r;
			ext_d_r <= ext_s_r;
		end
	end

	// reference: every clock internally, each external rising edge otherwise;
	// an external clock is therefore limited by the sampling rate
	assign ref_tick = (mode == MODE_USART_INT) ? 1'b1
		: (ext_s_r && !ext_d_r);

	// arithmetic baud: add 65536-baud each reference cycle, carry is a sample
	assign acc_sum   = {1'b0, acc_r} + (BAUD_PERIOD - {1'b0, baud_core_r});
	assign baud_tick = run && ref_tick && acc_sum[16];
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_r <= 16'h0000;
		end else if (!run) begin
			acc_r <= 16'h0000;
		end else if (ref_tick) begin
			acc_r <= acc_sum[15:0];
		end
	end

	// transmit buffer: a write while full is dropped
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			txbuf_r      <= 8'h00;
			txbuf_full_r <= 1'b0;
		end else if (wr_pend_r && wr_addr_r == OFS_DATA && !txbuf_full_r) begin
			txbuf_r      <= i_ahb.hwdata[7:0];
			txbuf_full_r <= 1'b1;
		end else if (txbuf_full_r && run
			&& (tx_state_r == TX_IDLE || tx_frame_end)) begin
			txbuf_full_r <= 1'b0;
		end
	end

	assign tx_frame_end = (tx_state_r == TX_SHIFT) && baud_tick
		&& tx_samp_r == SAMPLE_LAST && tx_bit_r == FRAME_BITS - 4'd1;

	// shifter: start, eight data lsb first, one stop; reload on the last
	// sample so the next start bit follows with no idle gap
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_state_r <= TX_IDLE;
			tx_sh_r    <= 10'h3FF;
			tx_samp_r  <= 4'h0;
			tx_bit_r   <= 4'h0;
		end else begin
			case (tx_state_r)
				TX_IDLE: begin
					if (txbuf_full_r && run) begin
						tx_sh_r    <= {1'b1, txbuf_r, 1'b0};
						tx_samp_r  <= 4'h0;
						tx_bit_r   <= 4'h0;
						tx_state_r <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (!run) begin
						tx_state_r <= TX_IDLE;
						tx_sh_r    <= 10'h3FF;
					end else if (tx_frame_end) begin
						tx_samp_r <= 4'h0;
						tx_bit_r  <= 4'h0;
						if (txbuf_full_r) begin
							tx_sh_r <= {1'b1, txbuf_r, 1'b0};
						end else begin
							tx_sh_r    <= 10'h3FF;
							tx_state_r <= TX_IDLE;
						end
					end else if (baud_tick) begin
						tx_samp_r <= tx_samp_r + 4'h1;
						if (tx_samp_r == SAMPLE_LAST) begin
							tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
							tx_bit_r <= tx_bit_r + 4'h1;
						end
					end
				end
				default: begin
					tx_state_r <= TX_IDLE;
				end
			endcase
		end
	end
	assign o_txd = tx_sh_r[0];

	// frame length in reference cycles; whole cycles by construction
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			frm_cnt_r  <= 16'h0000;
			frm_len_r  <= 16'h0000;
			frm_samp_r <= 8'h00;
		end else if (tx_state_r != TX_SHIFT) begin
			frm_cnt_r  <= 16'h0000;
			frm_samp_r <= 8'h00;
		end else if (tx_frame_end) begin
			frm_len_r  <= frm_cnt_r + 16'h0001;
			frm_cnt_r  <= 16'h0000;
			frm_samp_r <= 8'h00;
		end else begin
			if (ref_tick) begin
				frm_cnt_r <= frm_cnt_r + 16'h0001;
			end
			if (baud_tick) begin
				frm_samp_r <= frm_samp_r + 8'h01;
			end
		end
	end

	// receiver: false start rejected at mid-bit, stop sampled for framing
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_state_r <= RX_IDLE;
			rx_samp_r  <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_sh_r    <= 8'h00;
		end else if (!run) begin
			rx_state_r <= RX_IDLE;
		end else if (baud_tick) begin
			rx_samp_r <= rx_samp_r + 4'h1;
			case (rx_state_r)
				RX_IDLE: begin
					rx_samp_r <= 4'h0;
					if (!rxd_s_r) begin
						rx_state_r <= RX_START;
					end
				end
				RX_START: begin
					if (rx_samp_r == SAMPLE_MID) begin
						rx_samp_r  <= 4'h0;
						rx_bit_r   <= 4'h0;
						rx_state_r <= rxd_s_r ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_samp_r == SAMPLE_LAST) begin
						rx_sh_r  <= {rxd_s_r, rx_sh_r[7:1]};
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r == DATA_BITS - 4'd1) begin
							rx_state_r <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_samp_r == SAMPLE_LAST) begin
						rx_state_r <= RX_IDLE;
					end
				end
				default: begin
					rx_state_r <= RX_IDLE;
				end
			endcase
		end
	end
	assign rx_done = run && baud_tick && rx_state_r == RX_STOP
		&& rx_samp_r == SAMPLE_LAST;
	assign rx_entry.data      = rx_sh_r;
	assign rx_entry.frame_err = !rxd_s_r;

	rx_buffer2 u_rxbuf (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_push    (rx_done),
		.i_data    (rx_entry),
		.i_pop     (rd_data_pop),
		.o_head    (rx_head),
		.o_count   (rx_count)
	);

	// address comparator; i2c modes drop the top bit and compare seven
	assign match_val        = addr_r[ADDR_MATCH_LSB +: 8];
	assign match_mask_field = addr_r[ADDR_MASK_LSB +: 8];
	always_comb begin
		cmp_in = rx_sh_r;
		if (mode == MODE_I2C_SLV || mode == MODE_I2C_MST) begin
			cmp_in = {1'b0, rx_sh_r[6:0]};
		end
		case (amode)
			AMODE_MASK: addr_hit = ((cmp_in ^ match_val)
				& ~match_mask_field) == 8'h00;
			AMODE_TWO: addr_hit = cmp_in == match_val
				|| cmp_in == match_mask_field;
			AMODE_RANGE: addr_hit = cmp_in >= match_mask_field
				&& cmp_in <= match_val;
			default: addr_hit = 1'b0;
		endcase
	end

	// flag events and clears; a set in the clearing cycle wins
	always_comb begin
		flag_set = '0;
		flag_set[FLAG_DRE] = txbuf_full_r && run
			&& (tx_state_r == TX_IDLE || tx_frame_end);
		flag_set[FLAG_TXC]   = tx_frame_end && !txbuf_full_r;
		flag_set[FLAG_RXC]   = rx_done && rx_count != 2'd2;
		flag_set[FLAG_MATCH] = rx_done && addr_hit;
		flag_set[FLAG_ERR]   = rx_done
			&& (rx_count == 2'd2 || !rxd_s_r);
		flag_clr = '0;
		if (wr_pend_r && wr_addr_r == OFS_IRQ_FLAG) begin
			flag_clr = i_ahb.hwdata[NFLAG-1:0];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_r  <= '0;
			inten_r <= '0;
		end else begin
			flag_r <= (flag_r & ~flag_clr) | flag_set;
			if (wr_pend_r && wr_addr_r == OFS_IRQ_ENSET) begin
				inten_r <= inten_r | i_ahb.hwdata[NFLAG-1:0];
			end else if (wr_pend_r && wr_addr_r == OFS_IRQ_ENCLR) begin
				inten_r <= inten_r & ~i_ahb.hwdata[NFLAG-1:0];
			end
		end
	end

	// one shared line; no clock gating here, so it also serves as wake
	assign o_irq  = |(flag_r & inten_r);
	assign o_wake = o_irq;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_baud_write;
		wr_pend_r && wr_addr_r == OFS_BAUD;
	endsequence
	sequence s_flag_clear;
		wr_pend_r && wr_addr_r == OFS_IRQ_FLAG && flag_set == '0;
	endsequence

	chk_irq_follows_flag: assert property (
		$rose(flag_r[FLAG_RXC]) && inten_r[FLAG_RXC] |-> o_irq)
		else $error("irq not raised for enabled flag");
	chk_flag_w1c_clear: assert property (
		s_flag_clear ##0 i_ahb.hwdata[FLAG_RXC]
		|=> !flag_r[FLAG_RXC])
		else $error("flag not cleared by write of one");
	chk_enable_set_bit: assert property (
		wr_pend_r && wr_addr_r == OFS_IRQ_ENSET && i_ahb.hwdata[FLAG_ERR]
		|=> inten_r[FLAG_ERR])
		else $error("enable set write had no effect");
	chk_enable_clr_bit: assert property (
		wr_pend_r && wr_addr_r == OFS_IRQ_ENCLR && i_ahb.hwdata[FLAG_TXC]
		|=> !inten_r[FLAG_TXC] && !(flag_r[FLAG_TXC] && o_irq
		&& inten_r == '0))
		else $error("enable clear write had no effect");
	chk_baud_sync_lag: assert property (
		s_baud_write |-> ##[1:3] baud_core_r == baud_r)
		else $error("baud value did not reach core side");
	chk_mask_all_ones: assert property (
		amode == AMODE_MASK && match_mask_field == 8'hFF |-> addr_hit)
		else $error("all-ones mask rejected an address");
	chk_two_addr_hit: assert property (
		amode == AMODE_TWO && cmp_in == match_mask_field |-> addr_hit)
		else $error("second address not matched");
	chk_range_bounds: assert property (
		amode == AMODE_RANGE && addr_hit
		|-> cmp_in >= match_mask_field && cmp_in <= match_val)
		else $error("range match outside limits");
	chk_frame_samples: assert property (
		tx_frame_end |-> frm_samp_r == SAMPLES_PER_FRM - 8'h01)
		else $error("frame length not sixteen samples per bit");
	chk_gapless_reload: assert property (
		tx_frame_end && txbuf_full_r
		|=> tx_state_r == TX_SHIFT && !o_txd)
		else $error("buffered frame did not follow at once");
	chk_rx_depth: assert property (
		rx_done && rx_count == 2'd2 |=> rx_count == 2'd2 && flag_r[FLAG_ERR])
		else $error("overflow not flagged on full buffer");
	chk_reserved_idle: assert property (
		mode == MODE_RSVD6 || mode == MODE_RSVD7 |-> !baud_tick)
		else $error("reserved mode ran the engine");
endmodule
`default_nettype wire

// File: shared/serial_engine_pkg.sv
// constants, types and register map of the serial engine block
// Overview of operation
// - arithmetic baud average over 65536 reference cycles equals programmed rate
// - a baud change alters a frame only by whole reference cycles
// - cycles per frame equal ratio times data plus start and stop bits
// - at 48MHz, 8+2 bits: baud 0-406 gives 160, 407-808 gives 161
// - address compare: masked, two addresses or range; seven or eight bits
// - masked mode compares every bit not set in the mask field
// - all-zero mask accepts one address, all-ones mask accepts all
// - two-address mode matches match value or mask field as addresses
// - range mode matches mask field up to match value, ends included
// - each interrupt source owns a flag bit set on its condition
// - one to enable-set enables a source, one to enable-clear disables
// - request active while an enabled flag is set, until cleared or reset
// - all sources share one request line; software reads flags to tell
// - block keeps working in sleep while its clock runs; irq can wake
// - synchronized registers cross from bus side into the core side
// - one transmit buffer ahead of the shifter allows gapless frames
// - two-entry receive buffer keeps per-character error status
// - rate at most system clock internal, half system clock external
// - mode field: 0 ext usart, 1 int usart, 2-5 spi/i2c, 6-7 reserved
package serial_engine_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CTRLA    = 12'h000;
	localparam logic [11:0] OFS_BAUD     = 12'h004;
	localparam logic [11:0] OFS_ADDR     = 12'h008;
	localparam logic [11:0] OFS_IRQ_FLAG  = 12'h00C;
	localparam logic [11:0] OFS_IRQ_ENSET = 12'h010;
	localparam logic [11:0] OFS_IRQ_ENCLR = 12'h014;
	localparam logic [11:0] OFS_DATA     = 12'h018;
	localparam logic [11:0] OFS_STATUS   = 12'h01C;

	// field positions
	localparam int unsigned CTRLA_EN_BIT    = 0;
	localparam int unsigned OPERATING_MODE_FIELD_LSB  = 2;
	localparam int unsigned CTRLA_AMODE_LSB = 8;
	localparam int unsigned ADDR_MATCH_LSB  = 0;
	localparam int unsigned ADDR_MASK_LSB   = 16;
	localparam int unsigned STAT_FRMLEN_LSB = 16;

	// reset values
	localparam logic [31:0] CTRLA_RST = 32'h0000_0000;
	localparam logic [15:0] BAUD_RST  = 16'h0000;
	localparam logic [31:0] ADDR_RST  = 32'h0000_0000;

	// flag bit positions
	localparam int unsigned FLAG_DRE   = 0;
	localparam int unsigned FLAG_TXC   = 1;
	localparam int unsigned FLAG_RXC   = 2;
	localparam int unsigned FLAG_MATCH = 3;
	localparam int unsigned FLAG_ERR   = 4;
	localparam int unsigned NFLAG      = 5;

	// timing counts
	localparam logic [16:0] BAUD_PERIOD     = 17'h1_0000;
	localparam logic [3:0]  SAMPLE_LAST     = 4'hF;
	localparam logic [3:0]  SAMPLE_MID      = 4'h7;
	localparam logic [3:0]  FRAME_BITS      = 4'hA;
	localparam logic [3:0]  DATA_BITS       = 4'h8;
	localparam logic [7:0]  SAMPLES_PER_FRM = 8'hA0;

	typedef enum logic [2:0] {
		MODE_USART_EXT = 3'b000,
		MODE_USART_INT = 3'b001,
		MODE_SPI_SLV   = 3'b010,
		MODE_SPI_MST   = 3'b011,
		MODE_I2C_SLV   = 3'b100,
		MODE_I2C_MST   = 3'b101,
		MODE_RSVD6     = 3'b110,
		MODE_RSVD7     = 3'b111
	} operating_mode_t;

	typedef enum logic [1:0] {
		AMODE_MASK  = 2'b00,
		AMODE_TWO   = 2'b01,
		AMODE_RANGE = 2'b10,
		AMODE_RSVD  = 2'b11
	} addr_mode_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_t;

	typedef struct packed {
		logic       frame_err;
		logic [7:0] data;
	} rx_entry_t;

endpackage

// File: sim/tb_serial_engine.sv
// self-checking testbench for the serial engine block
`timescale 1ns/1ps
`default_nettype none
module tb_serial_engine
	import serial_engine_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        rxd = 1'b1;
	logic        ext_clk = 1'b0;
	ahb_req_t    req = '0;
	ahb_req_t    bus;
	ahb_rsp_t    rsp;
	logic        txd;
	logic        irq;
	logic        wake;
	logic [31:0] rd;
	int          mismatches = 0;
	int          samples_checked = 0;

	// fields: [28] match expected, [25:24] address mode, [23:16] mask, [15:8] match, [7:0] char
	localparam logic [31:0] CASES [13] = '{
		32'h1000_5A5A, 32'h0000_5A5B, 32'h10FF_00C3, 32'h100F_505F,
		32'h000F_506F, 32'h1134_1234, 32'h1134_1212, 32'h0134_1213,
		32'h1220_4020, 32'h1220_4040, 32'h0220_4041, 32'h0220_401F,
		32'h1220_4030};

	// clock, bus ready loop and serial loopback so every char comes back
	always #4 ref_clk = ~ref_clk;
	assign bus = {req[71:1], rsp.hreadyout};
	always @(posedge ref_clk) rxd <= txd;
	always @(posedge ref_clk) ext_clk <= ~ext_clk;

	// external clock runs at half rate so mode 0 gets one tick per two cycles
	serial_engine dut (
		.i_ref_clk (ref_clk),
		.i_rst     (rst),
		.i_ahb     (bus),
		.o_ahb     (rsp),
		.i_ext_clk (ext_clk),
		.i_rxd     (rxd),
		.o_txd     (txd),
		.o_irq     (irq),
		.o_wake    (wake)
	);

	task automatic wrap_up();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask

	// one single-word transfer; read data lands in rd at the data-phase edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		req.hsel <= 1'b1;
		req.haddr <= {20'h0_0000, a};
		req.htrans <= 2'b10;
		req.hwrite <= w;
		req.hsize <= 3'b010;
		@(posedge ref_clk);
		while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
		req.hsel <= 1'b0;
		req.htrans <= 2'b00;
		req.hwdata <= d;
		@(posedge ref_clk);
		while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
		rd = rsp.hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(what, e, rd);
	endtask

	// polls a register bit, bounded so a stuck bit fails instead of hanging
	task automatic wait_bit(input logic [11:0] a, input int b);
		int n;
		n = 0;
		rd = '0;
		while (rd[b] !== 1'b1 && n < 400) begin
			xfer(1'b0, a, 32'h0000_0000);
			n++;
		end
		chk("polled bit", 32'h1, {31'h0, rd[b]});
	endtask

	// irq is combinational from registers: let the write edge settle first
	task automatic chk_irq(input logic e);
		#1;
		chk("irq", {31'h0, e}, {31'h0, irq});
		chk("wake", {31'h0, e}, {31'h0, wake});
	endtask

	task automatic t_reset();
		chk("txd idle", 32'h1, {31'h0, txd});
		chk("hresp", 32'h0, {31'h0, rsp.hresp});
		chk_irq(1'b0);
		rdchk("ctrla", OFS_CTRLA, CTRLA_RST);
		rdchk("addr", OFS_ADDR, ADDR_RST);
		rdchk("baud", OFS_BAUD, {16'h0000, BAUD_RST});
		rdchk("unmapped", 12'h020, 32'h0000_0000);
		wr(OFS_IRQ_ENSET, 32'h0000_0014);
		rdchk("enable set", OFS_IRQ_ENSET, 32'h0000_0014);
		wr(OFS_IRQ_ENCLR, 32'h0000_0004);
		rdchk("enable clear", OFS_IRQ_ENCLR, 32'h0000_0010);
		wr(OFS_IRQ_ENCLR, 32'h0000_001F);
	endtask

	task automatic t_match();
		logic [31:0] e;
		for (int i = 0; i < 13; i++) begin
			e = CASES[i];
			wr(OFS_CTRLA, {22'h0, e[25:24], 8'h05});
			wr(OFS_ADDR, {8'h00, e[23:16], 8'h00, e[15:8]});
			wr(OFS_IRQ_FLAG, 32'h0000_001F);
			wr(OFS_DATA, {24'h0, e[7:0]});
			wait_bit(OFS_IRQ_FLAG, FLAG_RXC);
			chk("match flag", {31'h0, e[28]}, {31'h0, rd[FLAG_MATCH]});
			rdchk("rx char", OFS_DATA, {24'h0, e[7:0]});
		end
	endtask

	task automatic t_baud();
		logic [31:0] bv [2] = '{32'h0000_0197, 32'h0000_0000};
		logic [31:0] flen [2] = '{32'h0000_00A1, 32'h0000_00A0};
		for (int i = 0; i < 2; i++) begin
			wr(OFS_BAUD, bv[i]);
			wr(OFS_IRQ_FLAG, 32'h0000_001F);
			wr(OFS_DATA, 32'h0000_0096);
			wait_bit(OFS_IRQ_FLAG, FLAG_TXC);
			rdchk("rx char", OFS_DATA, 32'h0000_0096);
			xfer(1'b0, OFS_STATUS, 32'h0000_0000);
			chk("cycles per frame", flen[i], {16'h0, rd[31:16]});
		end
	endtask

	// external reference: frame length still counts reference ticks
	task automatic t_ext();
		wr(OFS_CTRLA, 32'h0000_0001);
		wr(OFS_IRQ_FLAG, 32'h0000_001F);
		wr(OFS_DATA, 32'h0000_005C);
		wait_bit(OFS_IRQ_FLAG, FLAG_TXC);
		rdchk("ext rx char", OFS_DATA, 32'h0000_005C);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("ext frame length", 32'h0000_00A0, {16'h0, rd[31:16]});
	endtask

	task automatic t_irq();
		wr(OFS_CTRLA, 32'h0000_0005);
		wr(OFS_ADDR, 32'h00FF_0000);
		wr(OFS_IRQ_FLAG, 32'h0000_001F);
		wr(OFS_DATA, 32'h0000_0077);
		wait_bit(OFS_IRQ_FLAG, FLAG_MATCH);
		rdchk("rx char", OFS_DATA, 32'h0000_0077);
		wr(OFS_IRQ_FLAG, 32'h0000_0000);
		wait_bit(OFS_IRQ_FLAG, FLAG_MATCH);
		chk_irq(1'b0);
		wr(OFS_IRQ_ENSET, 32'h0000_0008);
		chk_irq(1'b1);
		wr(OFS_IRQ_ENCLR, 32'h0000_0008);
		chk_irq(1'b0);
		wr(OFS_IRQ_ENSET, 32'h0000_0008);
		chk_irq(1'b1);
		wr(OFS_IRQ_FLAG, 32'h0000_0008);
		chk_irq(1'b0);
		xfer(1'b0, OFS_IRQ_FLAG, 32'h0000_0000);
		chk("flag cleared", 32'h0, {31'h0, rd[FLAG_MATCH]});
		wr(OFS_IRQ_ENCLR, 32'h0000_001F);
	endtask

	// two chars fill the receive buffer unread, the third must overflow
	task automatic t_overflow();
		wr(OFS_IRQ_FLAG, 32'h0000_001F);
		wr(OFS_DATA, 32'h0000_00A1);
		wait_bit(OFS_STATUS, 3);
		wr(OFS_DATA, 32'h0000_00B2);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("tx buffer full", 32'h1, {31'h0, rd[4]});
		wait_bit(OFS_STATUS, 2);
		wr(OFS_DATA, 32'h0000_00C3);
		wait_bit(OFS_IRQ_FLAG, FLAG_ERR);
		rdchk("first char", OFS_DATA, 32'h0000_00A1);
		rdchk("second char", OFS_DATA, 32'h0000_00B2);
		xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("rx count", 32'h0, {30'h0, rd[2:1]});
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_match();
		t_baud();
		t_irq();
		t_overflow();
		t_ext();
		wrap_up();
	end

	// watchdog: the whole sequence needs well under 15000 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire
